// ### hdl/level_readout_tieoff_regs.sv
// level readout, flag and manual tie-off register bank
`timescale 1ns/10ps
`default_nettype none
`include "level_tieoff_consts.svh"

module level_readout_tieoff_regs
    import level_tieoff_pkg::*;
(
    // clock and reset
    input  wire logic          clk_sys,
    input  wire logic          arst_n,
    // register port from the serial control decoder
    input  wire logic [6:0]    reg_addr,
    input  wire logic [8:0]    reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output var  logic [8:0]    reg_rdata,
    output var  logic          reg_rvalid,
    // live measurements from the level-control path
    input  wire level_status_t levels,
    // tie-off and peak-hold controls
    output var  tieoff_ctrl_t  tieoff_out,
    output var  logic          peak_hold_enable
);

    logic       manual_tieoff_enable_reg;
    logic [2:0] midsupply_pulldown_select_reg;
    logic       direct_buffer_ctrl_enable_reg;
    logic       tieoff_buffer_bypass_reg;
    logic       buffered_ref_tie_reg;
    logic       peak_hold_reg;
    logic       peak_clear;
    logic [8:0] left_p2p_level_reg;
    logic [8:0] right_p2p_level_reg;
    logic [8:0] left_peak_level_reg;
    logic [8:0] right_peak_level_reg;
    logic       left_gate_reg;
    logic       right_gate_reg;
    logic       left_rapid_reduce_flag;
    logic       right_rapid_reduce_flag;
    logic [8:0] rdata_next;
    logic [2:0] sel_decoded;

    function automatic logic [8:0] track(input logic [8:0] stored, input logic [8:0] live,
                                         input logic hold, input logic clr);
        if (!hold || clr) begin
            return live;
        end
        return (live > stored) ? live : stored;
    endfunction : track

    // one-cycle clear pulse when software writes one to the clear bit
    assign peak_clear = reg_wr && (reg_addr == `ADDR_PEAK_CTRL) && reg_wdata[`BIT_PEAK_CLEAR];

    // writable control bits; readout addresses take no write
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            manual_tieoff_enable_reg      <= `RESET_CTRL_BIT;
            midsupply_pulldown_select_reg <= `RESET_SEL;
            direct_buffer_ctrl_enable_reg <= `RESET_CTRL_BIT;
            tieoff_buffer_bypass_reg      <= `RESET_CTRL_BIT;
            buffered_ref_tie_reg          <= `RESET_CTRL_BIT;
            peak_hold_reg                 <= `RESET_CTRL_BIT;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `ADDR_PEAK_CTRL: begin
                    peak_hold_reg <= reg_wdata[`BIT_PEAK_HOLD];
                end
                `ADDR_TIEOFF_MODE: begin
                    manual_tieoff_enable_reg <= reg_wdata[`BIT_MANUAL_ENABLE];
                end
                `ADDR_PULLDOWN_SEL: begin
                    midsupply_pulldown_select_reg <= reg_wdata[2:0];
                end
                `ADDR_BUFFER_CTRL: begin
                    direct_buffer_ctrl_enable_reg <= reg_wdata[`BIT_DIRECT_ENABLE];
                    tieoff_buffer_bypass_reg      <= reg_wdata[`BIT_BUFFER_BYPASS];
                    buffered_ref_tie_reg          <= reg_wdata[`BIT_BUFFERED_REF];
                end
                default: begin
                end
            endcase
        end
    end

    // level capture: track live values, or keep the highest while held
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            left_p2p_level_reg   <= `RESET_LEVEL;
            right_p2p_level_reg  <= `RESET_LEVEL;
            left_peak_level_reg  <= `RESET_LEVEL;
            right_peak_level_reg <= `RESET_LEVEL;
        end else begin
            left_p2p_level_reg   <= track(left_p2p_level_reg, levels.p2p_left,
                                          peak_hold_reg, peak_clear);
            right_p2p_level_reg  <= track(right_p2p_level_reg, levels.p2p_right,
                                          peak_hold_reg, peak_clear);
            left_peak_level_reg  <= track(left_peak_level_reg, levels.peak_left,
                                          peak_hold_reg, peak_clear);
            right_peak_level_reg <= track(right_peak_level_reg, levels.peak_right,
                                          peak_hold_reg, peak_clear);
        end
    end

    // gate and rapid-reduction flags follow the live signal
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            left_gate_reg           <= 1'h0;
            right_gate_reg          <= 1'h0;
            left_rapid_reduce_flag  <= 1'h0;
            right_rapid_reduce_flag <= 1'h0;
        end else begin
            left_gate_reg           <= levels.gate_left;
            right_gate_reg          <= levels.gate_right;
            left_rapid_reduce_flag  <= levels.peak_left > `RAPID_THRESHOLD;
            right_rapid_reduce_flag <= levels.peak_right > `RAPID_THRESHOLD;
        end
    end

    // read multiplexer, unused bits zero
    always_comb begin
        rdata_next = 9'h000;
        unique case (reg_addr)
            `ADDR_PEAK_CTRL: begin
                rdata_next[`BIT_PEAK_HOLD] = peak_hold_reg;
            end
            `ADDR_TIEOFF_MODE: begin
                rdata_next[`BIT_MANUAL_ENABLE] = manual_tieoff_enable_reg;
            end
            `ADDR_PULLDOWN_SEL: begin
                rdata_next[2:0] = midsupply_pulldown_select_reg;
            end
            `ADDR_P2P_LEFT: begin
                rdata_next = left_p2p_level_reg;
            end
            `ADDR_P2P_RIGHT: begin
                rdata_next = right_p2p_level_reg;
            end
            `ADDR_PEAK_LEFT: begin
                rdata_next = left_peak_level_reg;
            end
            `ADDR_PEAK_RIGHT: begin
                rdata_next = right_peak_level_reg;
            end
            `ADDR_FLAGS: begin
                rdata_next[`BIT_GATE_RIGHT]  = right_gate_reg;
                rdata_next[`BIT_GATE_LEFT]   = left_gate_reg;
                rdata_next[`BIT_RAPID_LEFT]  = left_rapid_reduce_flag;
                rdata_next[`BIT_RAPID_RIGHT] = right_rapid_reduce_flag;
            end
            `ADDR_BUFFER_CTRL: begin
                rdata_next[`BIT_DIRECT_ENABLE] = direct_buffer_ctrl_enable_reg;
                rdata_next[`BIT_BUFFER_BYPASS] = tieoff_buffer_bypass_reg;
                rdata_next[`BIT_BUFFERED_REF]  = buffered_ref_tie_reg;
            end
            default: begin
                rdata_next = 9'h000;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata  <= 9'h000;
            reg_rvalid <= 1'h0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_next;
            end
        end
    end

    // one-hot pull-down decode; anything else selects no resistor
    always_comb begin
        unique case (midsupply_pulldown_select_reg)
            `SEL_SMALL_RES:  sel_decoded = `SEL_SMALL_RES;
            `SEL_MIDDLE_RES: sel_decoded = `SEL_MIDDLE_RES;
            `SEL_LARGE_RES:  sel_decoded = `SEL_LARGE_RES;
            default:         sel_decoded = `SEL_NONE;
        endcase
    end

    // tie-off control outputs, all registered
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tieoff_out       <= '0;
            peak_hold_enable <= 1'h0;
        end else begin
            tieoff_out.manual_tieoff_enable      <= manual_tieoff_enable_reg;
            tieoff_out.midsupply_pulldown_select <= manual_tieoff_enable_reg ?
                                                    sel_decoded : `SEL_NONE;
            tieoff_out.direct_buffer_ctrl_enable <= direct_buffer_ctrl_enable_reg;
            tieoff_out.tieoff_buffer_bypass      <= direct_buffer_ctrl_enable_reg &&
                                                    tieoff_buffer_bypass_reg;
            tieoff_out.buffered_ref_tie          <= direct_buffer_ctrl_enable_reg &&
                                                    buffered_ref_tie_reg;
            peak_hold_enable                     <= peak_hold_reg;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    pulldown_gated_a: assert property (
        !manual_tieoff_enable_reg |=> tieoff_out.midsupply_pulldown_select == `SEL_NONE)
        else $error("pull-down select active outside manual mode");

    pulldown_code_a: assert property (
        reg_wr && reg_addr == `ADDR_PULLDOWN_SEL && reg_wdata[2:0] == `SEL_LARGE_RES
        && manual_tieoff_enable_reg && !(reg_wr && reg_addr == `ADDR_TIEOFF_MODE)
        |=> ##1 tieoff_out.midsupply_pulldown_select == `SEL_LARGE_RES)
        else $error("large resistor code not applied");

    pulldown_onehot_a: assert property (
        $onehot0(tieoff_out.midsupply_pulldown_select))
        else $error("pull-down select not one-hot");

    p2p_left_read_a: assert property (
        reg_rd && reg_addr == `ADDR_P2P_LEFT
        |=> reg_rvalid && reg_rdata == $past(left_p2p_level_reg))
        else $error("left peak-to-peak readback wrong");

    p2p_right_track_a: assert property (
        !peak_hold_reg ##1 reg_rd && reg_addr == `ADDR_P2P_RIGHT
        |=> reg_rdata == $past(levels.p2p_right, 2))
        else $error("right peak-to-peak does not track");

    peak_left_read_a: assert property (
        reg_rd && reg_addr == `ADDR_PEAK_LEFT |=> reg_rdata == $past(left_peak_level_reg))
        else $error("left absolute peak readback wrong");

    peak_right_read_a: assert property (
        reg_rd && reg_addr == `ADDR_PEAK_RIGHT |=> reg_rdata == $past(right_peak_level_reg))
        else $error("right absolute peak readback wrong");

    gate_right_a: assert property (
        levels.gate_right ##1 reg_rd && reg_addr == `ADDR_FLAGS |=> reg_rdata[`BIT_GATE_RIGHT])
        else $error("right gate flag missing");

    gate_left_a: assert property (
        !levels.gate_left ##1 reg_rd && reg_addr == `ADDR_FLAGS |=> !reg_rdata[`BIT_GATE_LEFT])
        else $error("left gate flag stuck");

    rapid_left_a: assert property (
        levels.peak_left == 9'h1c0 |=> left_rapid_reduce_flag)
        else $error("left rapid flag not raised above threshold");

    rapid_right_a: assert property (
        levels.peak_right == `RAPID_THRESHOLD |=> !right_rapid_reduce_flag)
        else $error("right rapid flag raised at threshold");

    direct_off_a: assert property (
        !direct_buffer_ctrl_enable_reg |=> !tieoff_out.tieoff_buffer_bypass
        && !tieoff_out.buffered_ref_tie)
        else $error("buffer bits active without direct control");

    bypass_apply_a: assert property (
        direct_buffer_ctrl_enable_reg && tieoff_buffer_bypass_reg
        |=> tieoff_out.tieoff_buffer_bypass)
        else $error("buffer bypass not applied");

    vref_apply_a: assert property (
        direct_buffer_ctrl_enable_reg && buffered_ref_tie_reg |=> tieoff_out.buffered_ref_tie)
        else $error("buffered reference tie not applied");

    manual_mode_a: assert property (
        reg_wr && reg_addr == `ADDR_TIEOFF_MODE |=> ##1
        tieoff_out.manual_tieoff_enable == $past(reg_wdata[`BIT_MANUAL_ENABLE], 2))
        else $error("manual tie-off mode not applied");

    hold_retain_a: assert property (
        peak_hold_reg && !peak_clear |=> left_peak_level_reg >= $past(left_peak_level_reg))
        else $error("held peak dropped without clear");

    unused_zero_a: assert property (
        reg_rd && reg_addr == `ADDR_FLAGS |=> reg_rdata[8:6] == 3'h0 && reg_rdata[3:2] == 2'h0)
        else $error("unused flag bits not zero");

    rvalid_pulse_a: assert property (
        reg_rvalid == $past(reg_rd))
        else $error("read valid not one cycle after read strobe");

    readout_nowrite_a: assert property (
        reg_wr && reg_addr == `ADDR_P2P_LEFT && !peak_hold_reg
        |=> left_p2p_level_reg == $past(levels.p2p_left))
        else $error("write reached a readout register");

    clear_reload_a: assert property (
        peak_clear |=> right_peak_level_reg == $past(levels.peak_right))
        else $error("peak clear did not reload the live value");

    hold_output_a: assert property (
        peak_hold_enable == $past(peak_hold_reg))
        else $error("peak hold output does not follow its bit");

    rapid_read_a: assert property (
        reg_rd && reg_addr == `ADDR_FLAGS
        |=> reg_rdata[`BIT_RAPID_LEFT] == $past(left_rapid_reduce_flag))
        else $error("left rapid flag readback wrong");

    hold_clear_c: cover property (peak_hold_reg && peak_clear);
    manual_large_c: cover property (tieoff_out.midsupply_pulldown_select == `SEL_LARGE_RES);
    rapid_flag_c: cover property (left_rapid_reduce_flag && right_rapid_reduce_flag);
    direct_bypass_c: cover property (tieoff_out.tieoff_buffer_bypass);

endmodule : level_readout_tieoff_regs
`default_nettype wire

// ### hdl/level_tieoff_consts.svh
// register map, field positions, reset values and thresholds of the level readout block
`ifndef LEVEL_TIEOFF_CONSTS_SVH
`define LEVEL_TIEOFF_CONSTS_SVH

`define ADDR_PEAK_CTRL      7'h67
`define ADDR_TIEOFF_MODE    7'h6a
`define ADDR_PULLDOWN_SEL   7'h6b
`define ADDR_P2P_LEFT       7'h6c
`define ADDR_P2P_RIGHT      7'h6d
`define ADDR_PEAK_LEFT      7'h6e
`define ADDR_PEAK_RIGHT     7'h6f
`define ADDR_FLAGS          7'h70
`define ADDR_BUFFER_CTRL    7'h71

`define BIT_PEAK_CLEAR      7
`define BIT_PEAK_HOLD       6
`define BIT_MANUAL_ENABLE   8
`define BIT_DIRECT_ENABLE   8
`define BIT_BUFFER_BYPASS   6
`define BIT_BUFFERED_REF    5
`define BIT_GATE_RIGHT      5
`define BIT_GATE_LEFT       4
`define BIT_RAPID_LEFT      1
`define BIT_RAPID_RIGHT     0

`define SEL_SMALL_RES       3'h1
`define SEL_MIDDLE_RES      3'h2
`define SEL_LARGE_RES       3'h4
`define SEL_NONE            3'h0

`define RAPID_THRESHOLD     9'h1bf
`define RESET_CTRL_BIT      1'h0
`define RESET_SEL           3'h0
`define RESET_LEVEL         9'h000

`endif

// ### hdl/level_tieoff_pkg.sv
// types carried between the level path, the tie-off analog and this register block
package level_tieoff_pkg;

    typedef struct packed {
        logic [8:0] p2p_left;
        logic [8:0] p2p_right;
        logic [8:0] peak_left;
        logic [8:0] peak_right;
        logic       gate_left;
        logic       gate_right;
    } level_status_t;

    typedef struct packed {
        logic       manual_tieoff_enable;
        logic [2:0] midsupply_pulldown_select;
        logic       direct_buffer_ctrl_enable;
        logic       tieoff_buffer_bypass;
        logic       buffered_ref_tie;
    } tieoff_ctrl_t;

endpackage : level_tieoff_pkg

// ### tb/host_ctrl_model.sv
// host controller model driving the register port of the level readout block
`timescale 1ns/10ps
`default_nettype none

module host_ctrl_model (
    // clock and pace
    input  wire logic       clk_sys,
    input  wire logic       slow,
    // register port
    output var  logic [6:0] reg_addr,
    output var  logic [8:0] reg_wdata,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    input  wire logic [8:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    initial begin
        reg_addr  = 7'h00;
        reg_wdata = 9'h000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // one access; a read takes the data exactly one edge after the taking edge
    task automatic access(input logic wr, input logic [6:0] a, input logic [8:0] d,
                          output logic [8:0] q);
        q = 'x;
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= wr;
        reg_rd    <= !wr;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        if (!wr) begin
            @(posedge clk_sys);
            if (reg_rvalid === 1'b1) begin
                q = reg_rdata;
            end
        end
        // a slow host leaves gaps with a changing pattern on address and data
        repeat (slow ? 3 : 0) begin
            @(posedge clk_sys);
            reg_addr  <= ~reg_addr;
            reg_wdata <= ~reg_wdata;
        end
    endtask : access
endmodule : host_ctrl_model

`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the level readout and tie-off register bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end

module tb import level_tieoff_pkg::*;;
    logic          clk_sys = 1'b0;
    logic          arst_n  = 1'b0;
    logic          slow    = 1'b0;
    logic [6:0]    reg_addr;
    logic [8:0]    reg_wdata, reg_rdata, rd_val;
    logic          reg_wr, reg_rd, reg_rvalid, peak_hold_enable;
    level_status_t levels  = '0;
    tieoff_ctrl_t  tieoff_out;
    int            n_errors = 0, total_checks = 0;
    integer        seed = 81;
    int            m_man, m_sel, m_dir, m_byp, m_bref, m_hold, g_l, g_r;
    int            m_lvl[4], live[4];
    logic [6:0]    map_q[$] = '{7'h67, 7'h6a, 7'h6b, 7'h6c, 7'h6d, 7'h6e, 7'h6f, 7'h70,
                                7'h71, 7'h10, 7'h7f};
    logic [2:0]    sel_q[$] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h0, 3'h7};

    always #25 clk_sys = ~clk_sys;

    level_readout_tieoff_regs dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .levels(levels), .tieoff_out(tieoff_out), .peak_hold_enable(peak_hold_enable));

    host_ctrl_model host (
        .clk_sys(clk_sys), .slow(slow), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    function automatic logic [8:0] exp_rd(input logic [6:0] a);
        case (a)
            7'h67: return {2'h0, m_hold[0], 6'h00};
            7'h6a: return {m_man[0], 8'h00};
            7'h6b: return {6'h00, m_sel[2:0]};
            7'h6c, 7'h6d, 7'h6e, 7'h6f: return m_lvl[a - 7'h6c][8:0];
            7'h70: return {3'h0, g_r[0], g_l[0], 2'h0, live[2] > 447, live[3] > 447};
            7'h71: return {m_dir[0], 1'b0, m_byp[0], m_bref[0], 5'h00};
            default: return 9'h000;
        endcase
    endfunction : exp_rd

    function automatic tieoff_ctrl_t exp_tie();
        tieoff_ctrl_t t;
        t.manual_tieoff_enable      = m_man[0];
        t.midsupply_pulldown_select = (m_man == 1 && m_sel inside {1, 2, 4}) ? m_sel[2:0] : 3'h0;
        t.direct_buffer_ctrl_enable = m_dir[0];
        t.tieoff_buffer_bypass      = m_dir[0] & m_byp[0];
        t.buffered_ref_tie          = m_dir[0] & m_bref[0];
        return t;
    endfunction : exp_tie

    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        host.access(1'b1, a, d, rd_val);
        case (a)
            7'h67: begin m_hold = d[6]; if (d[7]) m_lvl = live; end
            7'h6a: m_man = d[8];
            7'h6b: m_sel = d[2:0];
            7'h71: begin m_dir = d[8]; m_byp = d[6]; m_bref = d[5]; end
            default: ;
        endcase
    endtask : wr

    task automatic rd(input logic [6:0] a, input string nm);
        logic [8:0] e;
        e = exp_rd(a);
        host.access(1'b0, a, 9'h000, rd_val);
        `CHK(nm, e, rd_val)
    endtask : rd

    task automatic rd_levels();
        for (int a = 'h6c; a <= 'h70; a++) rd(7'(a), "level readout");
    endtask : rd_levels

    task automatic chk_tie();
        repeat (3) @(posedge clk_sys);
        `CHK("tieoff_out", exp_tie(), tieoff_out)
    endtask : chk_tie

    task automatic set_lv(input int a, b, c, d, gl, gr);
        @(posedge clk_sys);
        levels <= '{a[8:0], b[8:0], c[8:0], d[8:0], gl[0], gr[0]};
        live = '{a, b, c, d};
        g_l = gl;
        g_r = gr;
        foreach (live[i]) m_lvl[i] = (m_hold && m_lvl[i] > live[i]) ? m_lvl[i] : live[i];
        repeat (2) @(posedge clk_sys);
    endtask : set_lv

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    initial begin
        #(8000 * 50);
        n_errors++;
        $display("watchdog expired");
        results();
    end

    initial begin
        {m_man, m_sel, m_dir, m_byp, m_bref, m_hold, g_l, g_r} = '0;
        m_lvl = '{0, 0, 0, 0};
        live = '{0, 0, 0, 0};
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        foreach (map_q[i]) rd(map_q[i], "reset value");
        chk_tie();
        $display("test reset done");
        set_lv(447, 448, 448, 447, 1, 0);
        rd_levels();
        set_lv(511, 0, 447, 448, 0, 1);
        rd_levels();
        repeat (6) begin
            set_lv($random(seed) & 'h1ff, $random(seed) & 'h1ff, $random(seed) & 'h1ff,
                   $random(seed) & 'h1ff, $random(seed) & 1, $random(seed) & 1);
            rd_levels();
        end
        for (int a = 'h6c; a <= 'h70; a++) wr(7'(a), 9'(a * 37));
        wr(7'h10, 9'h1ff);
        rd_levels();
        rd(7'h10, "unmapped");
        $display("test levels done");
        wr(7'h6b, 9'h004);
        chk_tie();
        wr(7'h6a, 9'h1ff);
        rd(7'h6a, "manual enable");
        foreach (sel_q[i]) begin
            wr(7'h6b, {6'h3f, sel_q[i]});
            chk_tie();
            rd(7'h6b, "pulldown select");
        end
        $display("test pulldown done");
        slow = 1'b1;
        for (int i = 0; i < 8; i++) begin
            wr(7'h71, {i[2], 1'b1, i[1], i[0], 5'h1f});
            chk_tie();
            rd(7'h71, "buffer ctrl");
        end
        $display("test buffer done");
        wr(7'h67, 9'h07f);
        repeat (2) @(posedge clk_sys);
        `CHK("peak_hold_enable", 1'b1, peak_hold_enable)
        set_lv(300, 200, 400, 100, 0, 0);
        set_lv(100, 250, 50, 90, 1, 1);
        rd_levels();
        wr(7'h67, 9'h0c0);
        set_lv(20, 20, 20, 20, 0, 1);
        rd_levels();
        rd(7'h67, "peak ctrl");
        wr(7'h67, 9'h000);
        set_lv(5, 6, 7, 8, 1, 0);
        rd_levels();
        $display("test hold done");
        wr(7'h6a, 9'h100);
        wr(7'h67, 9'h040);
        @(posedge clk_sys);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        {m_man, m_sel, m_dir, m_byp, m_bref, m_hold} = '0;
        m_lvl = live;
        `CHK("tieoff after reset", exp_tie(), tieoff_out)
        `CHK("hold after reset", 1'b0, peak_hold_enable)
        arst_n <= 1'b1;
        foreach (map_q[i]) rd(map_q[i], "after reset");
        $display("test second reset done");
        results();
    end
endmodule : tb

`default_nettype wire
